// ### verilog/cpa_top.sv
// Configuration port, index and data access with relocatable base address
`timescale 1ns/10ps
// Function
// - Bus or main reset: run mode, devices off
// - Low strap latched at reset: 0x2E/0x4E
// - High strap latched at reset: 0x16/0x00
// - Outside configuration, index/data accesses do nothing
// - Key 0x55 enters configuration state
// - Key 0xAA leaves configuration state
// - Base low bits 7..1, high bits 15..8
// - Writing high byte moves port at once
// - Base returns to default only on bus/main reset
// - Index reserved_global_slot ignores writes, reads zero
// - Test registers 0x19/0x25/0x2A reset on standby power-on reset
// - 0x29 bits 0,7 standby; 1..6 test reset
module cpa_top
(
  input wire logic clk_sys_in,
  input wire logic rst_in, // Host bus or main-supply power-on reset
  input wire logic standby_power_on_reset_in, // Standby power-on reset
  input wire logic internal_test_reset_in, // Internal test reset
  input wire logic base_low_strap_pin_in, // Low byte strap pin
  input wire logic base_high_strap_pin_in, // High byte strap pin
  input wire logic io_wr_in, // One-cycle I/O write strobe
  input wire logic io_rd_in, // One-cycle I/O read strobe
  input wire logic [15:0] io_addr_in, // I/O address
  input wire logic [7:0] io_wdata_in, // I/O write data
  output logic [7:0] io_rdata_out, // Read data, valid cycle after strobe
  output logic io_rvalid_out, // Read data valid pulse
  output logic config_mode_out, // High while in configuration state
  output logic [15:0] config_base_out, // Current config port address
  output logic devices_enabled_out // Logical device enable, off at reset
);
  cpa_sync_if strap_if ();
  logic base_low_strap; // Synchronised low strap level
  logic base_high_strap; // Synchronised high strap level
  logic strap_load_q; // Catch straps in the first cycle after release
  cpa_pkg::cpa_mode_t mode_q;
  cpa_pkg::cpa_mode_t mode_d;
  logic [7:0] base_low_q; // Low address byte (base low register)
  logic [7:0] base_high_q; // High address byte (base high register)
  logic [7:0] base_low_pend_q; // Low byte written, not yet applied
  logic [7:0] index_q; // Selected register number
  logic [7:0] test_a_q;
  logic [7:0] test_b_q;
  logic [7:0] test_c_q;
  logic [7:0] test_d_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic enable_q;

  assign strap_if.raw = {base_high_strap_pin_in, base_low_strap_pin_in};
  assign base_low_strap = strap_if.sync[0];
  assign base_high_strap = strap_if.sync[1];

  // Straps cross into the clock domain before they are latched
  cpa_sync u_sync
  (
    .clk_sys_in(clk_sys_in),
    .port(strap_if.sync_side)
  );

  // Address decode of the two ports
  wire [15:0] cur_base = {base_high_q, base_low_q};
  wire [15:0] data_addr = cur_base + cpa_pkg::DATA_PORT_STEP;
  wire hit_index = io_addr_in == cur_base;
  wire hit_data = io_addr_in == data_addr;
  wire in_cfg = mode_q == cpa_pkg::CPA_CONFIG;
  wire key_enter = io_wr_in && hit_index &&
                   io_wdata_in == cpa_pkg::KEY_ENTER;
  wire key_exit = io_wr_in && hit_index && in_cfg &&
                  io_wdata_in == cpa_pkg::KEY_EXIT;
  // Index and data traffic only counts in configuration state
  wire index_wr = io_wr_in && hit_index && in_cfg && !key_exit;
  wire data_wr = io_wr_in && hit_data && in_cfg;
  wire data_rd = io_rd_in && hit_data && in_cfg;
  wire index_rd = io_rd_in && hit_index && in_cfg;
  // Data port writes go to the register selected by the index
  wire wr_test_a = data_wr && index_q == cpa_pkg::IDX_TEST_A;
  wire wr_test_b = data_wr && index_q == cpa_pkg::IDX_TEST_B;
  wire wr_test_c = data_wr && index_q == cpa_pkg::IDX_TEST_C;
  wire wr_test_d = data_wr && index_q == cpa_pkg::IDX_TEST_D;
  wire wr_low = data_wr && index_q == cpa_pkg::IDX_BASE_LOW;
  wire wr_high = data_wr && index_q == cpa_pkg::IDX_BASE_HIGH;
  wire [7:0] low_default = base_low_strap ? cpa_pkg::LOW_STRAP1 :
                           cpa_pkg::LOW_STRAP0;
  wire [7:0] high_default = base_high_strap ? cpa_pkg::HIGH_STRAP1 :
                            cpa_pkg::HIGH_STRAP0;

  // Read mux; reserved slot and unknown indexes read zero
  logic [7:0] sel_data;
  always_comb
  begin
    sel_data = cpa_pkg::REG_ZERO;
    unique case (index_q)
      cpa_pkg::IDX_TEST_A: sel_data = test_a_q;
      cpa_pkg::IDX_TEST_B: sel_data = test_b_q;
      cpa_pkg::IDX_BASE_LOW: sel_data = base_low_pend_q;
      cpa_pkg::IDX_BASE_HIGH: sel_data = base_high_q;
      cpa_pkg::IDX_RSVD: sel_data = cpa_pkg::REG_ZERO;
      cpa_pkg::IDX_TEST_C: sel_data = test_c_q;
      cpa_pkg::IDX_TEST_D: sel_data = test_d_q;
      default: sel_data = cpa_pkg::REG_ZERO;
    endcase
  end

  // Mode transitions on key bytes
  always_comb
  begin
    mode_d = mode_q;
    if (key_exit)
    begin
      mode_d = cpa_pkg::CPA_RUN;
    end
    else if (key_enter && !in_cfg)
    begin
      mode_d = cpa_pkg::CPA_CONFIG;
    end
  end

  // Mode and device enable: bus reset puts us in run mode, all off
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      mode_q <= cpa_pkg::CPA_RUN;
      enable_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      enable_q <= 1'b0; // Logical devices live outside this block
    end
  end

  // Strap catch flag: high for the first cycle after reset release
  always_ff @(posedge clk_sys_in)
  begin
    strap_load_q <= rst_in;
  end

  // Base address: strap default after reset, relocated by high byte write
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || strap_load_q)
    begin
      // Only this reset restores the default, standby does not
      base_low_q <= low_default;
      base_high_q <= high_default;
      base_low_pend_q <= low_default;
    end
    else
    begin
      if (wr_low)
      begin
        base_low_pend_q <= io_wdata_in & cpa_pkg::BASE_LOW_MASK;
      end
      if (wr_high)
      begin
        // Move takes effect at once with the staged low byte
        base_high_q <= io_wdata_in;
        base_low_q <= base_low_pend_q;
      end
    end
  end

  // Index register selection
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      index_q <= cpa_pkg::REG_ZERO;
    end
    else if (index_wr)
    begin
      index_q <= io_wdata_in;
    end
  end

  // Test registers on standby power-on reset; bus or main reset alone keeps them
  always_ff @(posedge clk_sys_in)
  begin
    if (standby_power_on_reset_in)
    begin
      test_a_q <= cpa_pkg::REG_ZERO;
      test_b_q <= cpa_pkg::REG_ZERO;
      test_d_q <= cpa_pkg::REG_ZERO;
    end
    else
    begin
      if (wr_test_a)
      begin
        test_a_q <= io_wdata_in;
      end
      if (wr_test_b)
      begin
        test_b_q <= io_wdata_in;
      end
      if (wr_test_d)
      begin
        test_d_q <= io_wdata_in;
      end
    end
  end

  // Split reset domains inside the 0x29 test register
  logic [7:0] test_c_d;
  always_comb
  begin
    test_c_d = wr_test_c ? io_wdata_in : test_c_q;
    if (standby_power_on_reset_in)
    begin
      test_c_d = test_c_d & ~cpa_pkg::TEST_C_STBY_MASK;
    end
    if (internal_test_reset_in)
    begin
      test_c_d = test_c_d & cpa_pkg::TEST_C_STBY_MASK;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    test_c_q <= test_c_d;
  end

  // Read answer one cycle after the strobe; index port reads the index
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      rdata_q <= cpa_pkg::REG_ZERO;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= data_rd || index_rd;
      rdata_q <= data_rd ? sel_data :
                 index_rd ? index_q : cpa_pkg::REG_ZERO;
    end
  end

  assign io_rdata_out = rdata_q;
  assign io_rvalid_out = rvalid_q;
  assign config_mode_out = mode_q == cpa_pkg::CPA_CONFIG;
  assign config_base_out = cur_base;
  assign devices_enabled_out = enable_q;
endmodule : cpa_top

// ### common/cpa_pkg.sv
// Constants and types shared by the configuration port access block
package cpa_pkg;
  // Reset-time default address bytes, picked by the two straps
  localparam logic [7:0] LOW_STRAP0 = 8'h2e;
  localparam logic [7:0] LOW_STRAP1 = 8'h4e;
  localparam logic [7:0] HIGH_STRAP0 = 8'h16;
  localparam logic [7:0] HIGH_STRAP1 = 8'h00;
  // Key bytes written to the configuration port
  localparam logic [7:0] KEY_ENTER = 8'h55;
  localparam logic [7:0] KEY_EXIT = 8'haa;
  // Register indexes
  localparam logic [7:0] IDX_TEST_A = 8'h19;
  localparam logic [7:0] IDX_TEST_B = 8'h25;
  localparam logic [7:0] IDX_BASE_LOW = 8'h26;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h27;
  localparam logic [7:0] IDX_RSVD = 8'h28;
  localparam logic [7:0] IDX_TEST_C = 8'h29;
  localparam logic [7:0] IDX_TEST_D = 8'h2a;
  // Field layouts and reset values
  localparam logic [7:0] BASE_LOW_MASK = 8'hfe;
  localparam logic [7:0] TEST_C_STBY_MASK = 8'h81;
  localparam logic [7:0] REG_ZERO = 8'h00;
  localparam logic [15:0] DATA_PORT_STEP = 16'h0001;
  // Configuration access state
  typedef enum logic {CPA_RUN, CPA_CONFIG} cpa_mode_t;
endpackage : cpa_pkg

// ### common/cpa_sync_if.sv
// Interface carrying the synchronised strap levels to the main module
`timescale 1ns/10ps
interface cpa_sync_if;
  logic [1:0] raw; // Asynchronous pin levels
  logic [1:0] sync; // Levels after two flops
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface : cpa_sync_if

// ### verilog/cpa_sync.sv
// Two-flop synchroniser for the strap pins
`timescale 1ns/10ps
module cpa_sync
(
  input wire logic clk_sys_in,
  cpa_sync_if.sync_side port
);
  logic [1:0] meta_q; // First stage, read only by the second stage
  logic [1:0] sync_q; // Second stage

  // Straps are board levels; no reset needed, they settle in two cycles
  always_ff @(posedge clk_sys_in)
  begin
    meta_q <= port.raw;
    sync_q <= meta_q;
  end

  assign port.sync = sync_q;
endmodule : cpa_sync

// ### verification/cpa_top_asserts.sv
// Port checker for the configuration port access block
`timescale 1ns/10ps
module cpa_top_asserts
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic base_low_strap_pin_in,
  input wire logic base_high_strap_pin_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_rvalid_out,
  input wire logic config_mode_out,
  input wire logic [15:0] config_base_out,
  input wire logic devices_enabled_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // Write aimed at the config/index port
  wire logic port_wr = io_wr_in && io_addr_in == config_base_out;
  wire logic key_in = port_wr && io_wdata_in == cpa_pkg::KEY_ENTER;
  wire logic key_out = port_wr && io_wdata_in == cpa_pkg::KEY_EXIT;
  // Address the straps must select
  wire logic [15:0] strap_base = {
    base_high_strap_pin_in ? cpa_pkg::HIGH_STRAP1 : cpa_pkg::HIGH_STRAP0,
    base_low_strap_pin_in ? cpa_pkg::LOW_STRAP1 : cpa_pkg::LOW_STRAP0};
  property p_rv;
    io_rvalid_out |-> $past(io_rd_in) && $past(config_mode_out);
  endproperty
  a_rv: assert property (p_rv) else $error("stray read answer");
  property p_enter;
    key_in |=> config_mode_out;
  endproperty
  a_enter: assert property (p_enter) else $error("no entry");
  property p_exit;
    key_out |=> !config_mode_out;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");
  property p_locked;
    !config_mode_out && !key_in |=> !config_mode_out;
  endproperty
  a_locked: assert property (p_locked) else $error("unlocked");
  property p_off;
    devices_enabled_out == 1'b0;
  endproperty
  a_off: assert property (p_off) else $error("devices on");
  property p_even;
    config_base_out[0] == 1'b0;
  endproperty
  a_even: assert property (p_even) else $error("odd base");
  // Base only moves on a write or around a reset release
  property p_move;
    !$stable(config_base_out) |-> $past(io_wr_in) || $past(rst_in, 2);
  endproperty
  a_move: assert property (p_move) else $error("base moved");
  property p_strap;
    $fell(rst_in) |-> ##2 config_base_out == strap_base;
  endproperty
  a_strap: assert property (p_strap) else $error("strap base");
  c_enter: cover property (key_in);
  c_read: cover property (io_rvalid_out);
  c_move: cover property (!$stable(config_base_out));
endmodule : cpa_top_asserts
bind cpa_top cpa_top_asserts cpa_top_asserts_inst (.*);

// ### verification/cpa_host.sv
// Host model issuing one-cycle I/O port cycles
`timescale 1ns/10ps
module cpa_host
(
  input wire logic clk_sys_in,
  input wire logic [7:0] io_rdata_in,
  input wire logic io_rvalid_in,
  output logic io_wr_out,
  output logic io_rd_out,
  output logic [15:0] io_addr_out,
  output logic [7:0] io_wdata_out
);
  initial
  begin
    io_wr_out = 1'b0;
    io_rd_out = 1'b0;
    io_addr_out = 16'h0000;
    io_wdata_out = 8'h00;
  end
  // Address and data are inverted and strobes cleared after release so stale values never look valid
  task automatic cycle(input logic w, input logic [15:0] a,
    input logic [7:0] d);
    @(negedge clk_sys_in);
    io_wr_out = w;
    io_rd_out = !w;
    io_addr_out = a;
    io_wdata_out = d;
    @(negedge clk_sys_in);
    io_wr_out = 1'b0;
    io_rd_out = 1'b0;
    io_addr_out = ~a;
    io_wdata_out = ~d;
  endtask : cycle
  // Answer is one cycle after the strobe; no answer reads as zero
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    cycle(1'b0, a, 8'h00);
    d = io_rvalid_in ? {8'h01, io_rdata_in} : 16'h0000;
  endtask : rd
endmodule : cpa_host

// ### verification/tb_config_port_index_data_access.sv
// Self-checking bench for the configuration port access block
`timescale 1ns/10ps
module tb_config_port_index_data_access;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic stby = 1'b1;
  logic tst = 1'b1;
  logic [1:0] strap = 2'b00;
  logic wr, rd, rvalid, mode, dev;
  logic [15:0] addr, base, got;
  logic [15:0] cfg = 16'h162e;
  logic [7:0] wdata, rdata;
  int miscompares = 0;
  int compares = 0;
  always #5 clk_sys = ~clk_sys;
  cpa_top cpa_top_inst (.clk_sys_in(clk_sys), .rst_in(rst),
    .standby_power_on_reset_in(stby), .internal_test_reset_in(tst),
    .base_low_strap_pin_in(strap[0]), .base_high_strap_pin_in(strap[1]),
    .io_wr_in(wr), .io_rd_in(rd), .io_addr_in(addr), .io_wdata_in(wdata),
    .io_rdata_out(rdata), .io_rvalid_out(rvalid), .config_mode_out(mode),
    .config_base_out(base), .devices_enabled_out(dev));
  cpa_host cpa_host_inst (.clk_sys_in(clk_sys), .io_rdata_in(rdata),
    .io_rvalid_in(rvalid), .io_wr_out(wr), .io_rd_out(rd),
    .io_addr_out(addr), .io_wdata_out(wdata));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Index then data port, at the expected base
  task automatic wr_reg(input logic [7:0] i, input logic [7:0] v);
    cpa_host_inst.cycle(1'b1, cfg, i);
    cpa_host_inst.cycle(1'b1, cfg + 16'h0001, v);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] i);
    cpa_host_inst.cycle(1'b1, cfg, i);
    cpa_host_inst.rd(cfg + 16'h0001, got);
  endtask : rd_reg
  // Straps are held three cycles before release
  task automatic do_reset(input logic [1:0] s);
    @(negedge clk_sys);
    rst = 1'b1;
    strap = s;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    cfg = {s[1] ? 8'h00 : 8'h16, s[0] ? 8'h4e : 8'h2e};
    repeat (3) @(negedge clk_sys);
    chk(base, cfg);
    chk(16'({mode, dev}), 16'h0000);
  endtask : do_reset
  task automatic test_lock_and_regs;
    logic [7:0] idx [5] = '{8'h19, 8'h25, 8'h2a, 8'h29, 8'h28};
    wr_reg(8'h19, 8'h5a);
    rd_reg(8'h19);
    chk(got, 16'h0000);
    cpa_host_inst.cycle(1'b1, cfg, 8'h55);
    chk(16'(mode), 16'h0001);
    rd_reg(8'h19);
    chk(got, 16'h0100);
    foreach (idx[k])
    begin
      wr_reg(idx[k], 8'hc3);
      rd_reg(idx[k]);
      chk(got, idx[k] == 8'h28 ? 16'h0100 : 16'h01c3);
    end
  endtask : test_lock_and_regs
  task automatic test_test_resets;
    wr_reg(8'h29, 8'hff);
    @(negedge clk_sys) tst = 1'b1;
    @(negedge clk_sys) tst = 1'b0;
    rd_reg(8'h29);
    chk(got, 16'h0181);
    // Refill, so the standby pulse must spare bits 1 to 6
    wr_reg(8'h29, 8'hff);
    @(negedge clk_sys) stby = 1'b1;
    @(negedge clk_sys) stby = 1'b0;
    rd_reg(8'h29);
    chk(got, 16'h017e);
    rd_reg(8'h2a);
    chk(got, 16'h0100);
    rd_reg(8'h19);
    chk(got, 16'h0100);
  endtask : test_test_resets
  task automatic test_move;
    wr_reg(8'h26, 8'h61);
    rd_reg(8'h26);
    chk(got, 16'h0160);
    chk(base, cfg);
    wr_reg(8'h27, 8'h12);
    chk(base, 16'h1260);
    cfg = 16'h1260;
    rd_reg(8'h27);
    chk(got, 16'h0112);
    // Index port read returns the selected register number
    cpa_host_inst.rd(cfg, got);
    chk(got, 16'h0127);
    cpa_host_inst.cycle(1'b1, cfg, 8'haa);
    chk(16'(mode), 16'h0000);
    @(negedge clk_sys) stby = 1'b1;
    @(negedge clk_sys) stby = 1'b0;
    chk(base, 16'h1260);
    do_reset(2'b00);
  endtask : test_move
  initial
  begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
  // First pass doubles as the power-up reset of four cycles
  initial
  begin
    for (int i = 3; i >= 0; i--)
    begin
      do_reset(2'(i));
      // Power resets cleared the test registers during the first pass
      stby = 1'b0;
      tst = 1'b0;
    end
    test_lock_and_regs;
    test_test_resets;
    test_move;
    tally_and_finish;
  end
endmodule : tb_config_port_index_data_access
